// File: include/overtemp_pkg.sv
package overtemp_pkg;
  // ************************************************************
  // Code and current source.
  // ************************************************************
  localparam int          CODE_W           = 8;
  localparam logic [7:0]  CODE_MAX         = 8'hff;
  localparam logic [7:0]  CODE_MIN         = 8'h00;
  localparam logic [7:0]  CODE_RESET       = 8'h00;
  localparam int          CODE_SPAN        = 256;
  localparam int          FULL_SCALE_UA    = 80;
  localparam int          REF_MV           = 1250;
  // ************************************************************
  // Thresholds as codes, from code = 4 Mohm / (R_ntc + R_s).
  // ************************************************************
  localparam int          SERIES_OHM       = 14000;
  localparam int          EQUIV_OHM        = CODE_SPAN * REF_MV * 1000 / FULL_SCALE_UA;
  localparam logic [7:0]  CODE_TRIP        = 8'(EQUIV_OHM / (SERIES_OHM + 2500));
  localparam logic [7:0]  CODE_CLEAR       = 8'(EQUIV_OHM / (SERIES_OHM + 4000));
  localparam logic [7:0]  CODE_DIM_START   = 8'(EQUIV_OHM / (SERIES_OHM + 6300));
  localparam logic [7:0]  CODE_DIM_END     = CODE_TRIP;
  localparam logic [7:0]  CODE_DISABLED    = 8'h14;
  // ************************************************************
  // Timing.
  // ************************************************************
  localparam int          CLK_HZ           = 125000000;
  localparam int          STEP_HALF_CYCLES = 7;
  localparam int          FAST_MS          = 5;
  localparam int          FAST_STEP_CYC    = (FAST_MS * (CLK_HZ / 1000)) / CODE_SPAN;
  localparam int          NOISE_SHIFT      = 2;
  localparam int          SLOW_SHIFT       = 12;
  localparam logic [7:0]  DIM_FULL         = 8'hff;
endpackage

// File: include/step_if.sv
`timescale 1ns/10ps
interface step_if;
  logic       step;
  logic [7:0] code;
  logic [7:0] filt;
  modport src (output step, input code, input filt);
  modport dst (input step, output code, output filt);
endinterface

// File: hdl/code_filter.sv
`timescale 1ns/10ps
module code_filter
  import overtemp_pkg::*;
#(
  parameter int SHIFT = NOISE_SHIFT
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Sample strobe and raw code.
  input  wire logic       sample,
  input  wire logic [7:0] raw,
  // Filtered code.
  output logic      [7:0] filt
);
  logic [7+SHIFT:0] acc_ff;
  logic [7+SHIFT:0] nxt_acc;
  logic [8+SHIFT:0] sum;

  always_comb begin
    sum     = {1'b0, acc_ff} + {{(SHIFT+1){1'b0}}, raw} - {{(SHIFT+1){1'b0}}, acc_ff[7+SHIFT:SHIFT]};
    nxt_acc = acc_ff;
    if (sample) begin
      nxt_acc = sum[7+SHIFT:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  assign filt = acc_ff[7+SHIFT:SHIFT];
endmodule

// File: hdl/thermistor_overtemp_tracker.sv
// Functional notes
// - Loop holds sense pin at reference.
// - Code drives proportional 80 uA current source.
// - One step every seventh half line-cycle.
// - Larger code means hotter sensor.
// - Filtered code above trip shuts down.
// - Fault self-clears below 110 degree code.
// - Fast startup track, then check, then enable.
// - Slow filter scales dim above 95.
// - Dim scaling spans 6.3k to 2.5k.
// - Pull-down resistor disables protection.
`timescale 1ns/10ps
module thermistor_overtemp_tracker
  import overtemp_pkg::*;
#(
  parameter int FAST_CYC = FAST_STEP_CYC
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Analogue comparator and line timing.
  input  wire logic       sense_above_ref,
  input  wire logic       half_cycle,
  // Current source setting.
  output logic      [7:0] current_code,
  // System controls.
  output logic            overtemp_fault,
  output logic            stages_enable,
  output logic            protect_disabled,
  output logic      [7:0] dim_scale
);
  // ************************************************************
  // Startup state machine.
  // ************************************************************
  typedef enum logic [1:0] {ST_TRACK, ST_CHECK, ST_RUN} phase_t;

  phase_t       phase_ff;
  phase_t       nxt_phase;
  logic [7:0]   code_ff;
  logic [7:0]   nxt_code;
  logic [2:0]   half_cnt_ff;
  logic [2:0]   nxt_half_cnt;
  logic [31:0]  fast_cnt_ff;
  logic [31:0]  nxt_fast_cnt;
  logic [8:0]   fast_steps_ff;
  logic [8:0]   nxt_fast_steps;
  logic         step;
  logic         fault_ff;
  logic         nxt_fault;
  logic         enable_ff;
  logic         nxt_enable;
  logic         disabled_ff;
  logic         nxt_disabled;
  logic [7:0]   dim_ff;
  logic [7:0]   nxt_dim;
  logic [7:0]   filt_noise;
  logic [7:0]   filt_slow;
  logic [15:0]  dim_prod;

  step_if sif ();

  // ************************************************************
  // Step timing.
  // ************************************************************
  always_comb begin
    nxt_half_cnt   = half_cnt_ff;
    nxt_fast_cnt   = fast_cnt_ff;
    nxt_fast_steps = fast_steps_ff;
    step           = 1'b0;
    if (phase_ff == ST_TRACK) begin
      if (fast_cnt_ff >= 32'(FAST_CYC - 1)) begin
        nxt_fast_cnt   = '0;
        step           = 1'b1;
        nxt_fast_steps = fast_steps_ff + 9'h001;
      end else begin
        nxt_fast_cnt = fast_cnt_ff + 32'h1;
      end
    end else if (half_cycle) begin
      if (half_cnt_ff == 3'(STEP_HALF_CYCLES - 1)) begin
        nxt_half_cnt = '0;
        step         = 1'b1;
      end else begin
        nxt_half_cnt = half_cnt_ff + 3'h1;
      end
    end
  end

  // ************************************************************
  // Tracking loop.
  // ************************************************************
  always_comb begin
    nxt_code = code_ff;
    if (step) begin
      // Sense high means too much current for the network, so step down.
      if (sense_above_ref) begin
        if (code_ff != CODE_MIN) begin
          nxt_code = code_ff - 8'h01;
        end
      end else begin
        if (code_ff != CODE_MAX) begin
          nxt_code = code_ff + 8'h01;
        end
      end
    end
  end

  assign sif.step = step;
  assign sif.code = code_ff;

  code_filter #(
    .SHIFT (NOISE_SHIFT)
  ) u_noise (
    .clk    (clk),
    .rst    (rst),
    .sample (sif.step),
    .raw    (sif.code),
    .filt   (filt_noise)
  );

  code_filter #(
    .SHIFT (SLOW_SHIFT)
  ) u_slow (
    .clk    (clk),
    .rst    (rst),
    .sample (sif.step),
    .raw    (sif.code),
    .filt   (filt_slow)
  );

  assign sif.filt = filt_noise;

  // ************************************************************
  // Protection and startup.
  // ************************************************************
  always_comb begin
    nxt_phase    = phase_ff;
    nxt_fault    = fault_ff;
    nxt_enable   = enable_ff;
    // A small code after fast tracking means the pin is pulled down.
    nxt_disabled = disabled_ff;
    unique case (phase_ff)
      ST_TRACK: begin
        if (fast_steps_ff == 9'(CODE_SPAN)) begin
          nxt_phase = ST_CHECK;
        end
      end
      ST_CHECK: begin
        nxt_disabled = (code_ff <= CODE_DISABLED);
        if (code_ff <= CODE_DISABLED || code_ff < CODE_CLEAR) begin
          nxt_phase  = ST_RUN;
          nxt_enable = 1'b1;
        end
      end
      ST_RUN: begin
        if (!disabled_ff) begin
          if (sif.filt > CODE_TRIP) begin
            nxt_fault  = 1'b1;
            nxt_enable = 1'b0;
          end else if (fault_ff && sif.filt < CODE_CLEAR) begin
            nxt_fault  = 1'b0;
            nxt_enable = 1'b1;
          end
        end
      end
    endcase
  end

  // ************************************************************
  // Dim scaling.
  // ************************************************************
  always_comb begin
    dim_prod = 16'(filt_slow - CODE_DIM_START) * 16'(DIM_FULL);
    nxt_dim  = DIM_FULL;
    if (!disabled_ff && phase_ff == ST_RUN && filt_slow > CODE_DIM_START) begin
      if (filt_slow >= CODE_DIM_END) begin
        nxt_dim = 8'h00;
      end else begin
        nxt_dim = DIM_FULL - 8'(dim_prod / 16'(CODE_DIM_END - CODE_DIM_START));
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_ff      <= ST_TRACK;
      code_ff       <= CODE_RESET;
      half_cnt_ff   <= '0;
      fast_cnt_ff   <= '0;
      fast_steps_ff <= '0;
      fault_ff      <= 1'b0;
      enable_ff     <= 1'b0;
      disabled_ff   <= 1'b0;
      dim_ff        <= DIM_FULL;
    end else begin
      phase_ff      <= nxt_phase;
      code_ff       <= nxt_code;
      half_cnt_ff   <= nxt_half_cnt;
      fast_cnt_ff   <= nxt_fast_cnt;
      fast_steps_ff <= nxt_fast_steps;
      fault_ff      <= nxt_fault;
      enable_ff     <= nxt_enable;
      disabled_ff   <= nxt_disabled;
      dim_ff        <= nxt_dim;
    end
  end

  // The code is the current source setting directly.
  assign current_code     = code_ff;
  assign overtemp_fault   = fault_ff;
  assign stages_enable    = enable_ff;
  assign protect_disabled = disabled_ff;
  assign dim_scale        = dim_ff;

  // ************************************************************
  // Checks.
  // ************************************************************
  property p_step_one;
    @(posedge clk) disable iff (rst)
      step |=> (code_ff == $past(code_ff) + 8'h01) || (code_ff == $past(code_ff) - 8'h01)
               || (code_ff == $past(code_ff));
  endproperty
  a_step_one: assert property (p_step_one) else $error("code moved more than one step");

  property p_hold;
    @(posedge clk) disable iff (rst)
      !step |=> $stable(code_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("code moved without step");

  property p_sat_hi;
    @(posedge clk) disable iff (rst)
      (code_ff == CODE_MAX && !sense_above_ref) |=> code_ff == CODE_MAX;
  endproperty
  a_sat_hi: assert property (p_sat_hi) else $error("code wrapped high");

  property p_sat_lo;
    @(posedge clk) disable iff (rst)
      (code_ff == CODE_MIN && sense_above_ref) |=> code_ff == CODE_MIN;
  endproperty
  a_sat_lo: assert property (p_sat_lo) else $error("code wrapped low");

  property p_down;
    @(posedge clk) disable iff (rst)
      (step && sense_above_ref && code_ff != CODE_MIN) |=> code_ff == $past(code_ff) - 8'h01;
  endproperty
  a_down: assert property (p_down) else $error("code did not step down");

  property p_trip;
    @(posedge clk) disable iff (rst)
      (phase_ff == ST_RUN && !disabled_ff && filt_noise > CODE_TRIP) |=> fault_ff && !enable_ff;
  endproperty
  a_trip: assert property (p_trip) else $error("no shutdown above trip");

  property p_clear;
    @(posedge clk) disable iff (rst)
      (phase_ff == ST_RUN && fault_ff && !disabled_ff && filt_noise < CODE_CLEAR) |=> !fault_ff;
  endproperty
  a_clear: assert property (p_clear) else $error("fault did not clear");

  property p_start_gate;
    @(posedge clk) disable iff (rst)
      (phase_ff != ST_RUN) |-> !enable_ff;
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("stages on before check");

  property p_dim_off;
    @(posedge clk) disable iff (rst)
      (filt_slow <= CODE_DIM_START) |=> dim_ff == DIM_FULL;
  endproperty
  a_dim_off: assert property (p_dim_off) else $error("dim scaled below start");

  property p_dim_end;
    @(posedge clk) disable iff (rst)
      (phase_ff == ST_RUN && !disabled_ff && filt_slow >= CODE_DIM_END) |=> dim_ff == 8'h00;
  endproperty
  a_dim_end: assert property (p_dim_end) else $error("dim not minimum at end");

  property p_up;
    @(posedge clk) disable iff (rst)
      (step && !sense_above_ref && code_ff != CODE_MAX) |=> code_ff == $past(code_ff) + 8'h01;
  endproperty
  a_up: assert property (p_up) else $error("code did not step up");

  property p_step_rate;
    @(posedge clk) disable iff (rst)
      (step && phase_ff != ST_TRACK) |=> !step [*6];
  endproperty
  a_step_rate: assert property (p_step_rate) else $error("steps too close");

  property p_check_wait;
    @(posedge clk) disable iff (rst)
      (phase_ff == ST_CHECK && code_ff >= CODE_CLEAR) |=> !enable_ff;
  endproperty
  a_check_wait: assert property (p_check_wait) else $error("stages on while hot");

  property p_fault_off;
    @(posedge clk) disable iff (rst)
      fault_ff |-> !enable_ff;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("stages on during fault");

  property p_disabled_quiet;
    @(posedge clk) disable iff (rst)
      disabled_ff |=> !fault_ff && dim_ff == DIM_FULL;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled but active");
endmodule

// File: verification/ntc_network_model.sv
`timescale 1ns/10ps
module ntc_network_model
  import overtemp_pkg::*;
(
  // Current source setting from the block.
  input  wire logic [7:0]  current_code,
  // Total network resistance in ohms.
  input  wire logic [31:0] net_ohm,
  // Comparator result.
  output logic             sense_above_ref
);
  // ************************************************************
  // Network voltage against the reference.
  // ************************************************************
  // The resistance stands for thermistor plus series resistor or a pull-down.
  always_comb begin
    sense_above_ref = (64'(current_code) * 64'(net_ohm) * 64'(FULL_SCALE_UA))
                      > (64'(REF_MV) * 64'd1000 * 64'(CODE_SPAN));
  end
endmodule

// File: verification/tb_thermistor_overtemp_tracker.sv
`timescale 1ns/10ps
module tb_thermistor_overtemp_tracker;
  import overtemp_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        half_cycle = 1'b0;
  logic [31:0] net_ohm = 32'd24000;
  logic        sense_above_ref;
  logic [7:0]  current_code;
  logic        overtemp_fault;
  logic        stages_enable;
  logic        protect_disabled;
  logic [7:0]  dim_scale;
  int          n_fail = 0;
  int          checked = 0;
  // ************************************************************
  // Clock, design and network.
  // ************************************************************
  always #4 clk = ~clk;
  thermistor_overtemp_tracker #(.FAST_CYC(2)) thermistor_overtemp_tracker_inst (
    .clk(clk), .rst(rst), .sense_above_ref(sense_above_ref), .half_cycle(half_cycle),
    .current_code(current_code), .overtemp_fault(overtemp_fault),
    .stages_enable(stages_enable), .protect_disabled(protect_disabled),
    .dim_scale(dim_scale));
  ntc_network_model ntc_network_model_inst (
    .current_code(current_code), .net_ohm(net_ohm), .sense_above_ref(sense_above_ref));
  // ************************************************************
  // Shared tasks.
  // ************************************************************
  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hc(input int n);
    repeat (n) begin
      @(posedge clk) half_cycle <= 1'b1;
      @(posedge clk) half_cycle <= 1'b0;
      #1;
    end
  endtask
  task automatic hc_wait(input logic f, input logic e, input int bound);
    int i;
    i = 0;
    while (!(overtemp_fault === f && stages_enable === e) && i < bound) begin
      hc(1);
      i++;
    end
    if (!(overtemp_fault === f && stages_enable === e)) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, {overtemp_fault, stages_enable}, {f, e});
      tally_and_finish();
    end
  endtask
  task automatic do_reset(input logic [31:0] ohm);
    @(posedge clk) rst <= 1'b1;
    net_ohm <= ohm;
    repeat (2) @(posedge clk);
    #1;
    chk(current_code, 8'h00);
    chk({overtemp_fault, stages_enable, protect_disabled}, 8'h00);
    chk(dim_scale, 8'hff);
    @(posedge clk) rst <= 1'b0;
  endtask
  // ************************************************************
  // Scenarios.
  // ************************************************************
  task automatic sc_cool_start();
    do_reset(32'd24000);
    repeat (500) @(posedge clk);
    #1;
    chk(8'(stages_enable), 8'h00);
    hc_wait(1'b0, 1'b1, 20);
    chk(8'(current_code >= 8'ha5 && current_code <= 8'ha8), 8'h01);
    chk(dim_scale, 8'hff);
    chk(8'(protect_disabled), 8'h00);
  endtask
  task automatic sc_step_cadence();
    logic [7:0] prev;
    int         k;
    prev = current_code;
    k = 0;
    while (current_code === prev && k < 8) begin
      hc(1);
      k++;
    end
    if (current_code === prev) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, current_code, prev + 8'h01);
      tally_and_finish();
    end
    prev = current_code;
    k = 0;
    while (current_code === prev && k < 10) begin
      hc(1);
      k++;
    end
    if (current_code === prev) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, current_code, prev + 8'h01);
      tally_and_finish();
    end
    chk(8'(k), 8'h07);
    chk(8'(current_code > prev ? current_code - prev : prev - current_code), 8'h01);
  endtask
  task automatic sc_overtemp();
    logic [7:0] prev;
    @(posedge clk) net_ohm <= 32'd16000;
    hc_wait(1'b1, 1'b0, 840);
    chk(8'(current_code > CODE_TRIP), 8'h01);
    prev = current_code;
    hc(7);
    chk(8'(current_code !== prev), 8'h01);
    @(posedge clk) net_ohm <= 32'd24000;
    hc_wait(1'b0, 1'b1, 840);
    chk(8'(current_code < CODE_CLEAR), 8'h01);
  endtask
  task automatic sc_hot_start();
    do_reset(32'd1000);
    repeat (600) @(posedge clk);
    #1;
    chk(current_code, 8'hff);
    chk(8'(stages_enable), 8'h00);
    hc(14);
    chk(current_code, 8'hff);
    chk(8'(stages_enable), 8'h00);
    @(posedge clk) net_ohm <= 32'd24000;
    hc_wait(1'b0, 1'b1, 420);
  endtask
  task automatic sc_disabled();
    do_reset(32'd400000);
    repeat (600) @(posedge clk);
    #1;
    hc(14);
    chk(8'(protect_disabled), 8'h01);
    chk(8'(current_code <= 8'h14), 8'h01);
    chk({overtemp_fault, stages_enable}, 8'h01);
    chk(dim_scale, 8'hff);
  endtask
  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    sc_cool_start();
    sc_step_cadence();
    sc_overtemp();
    sc_hot_start();
    sc_disabled();
    tally_and_finish();
  end
endmodule
